// *** bench/gsbh_target_model.sv ***
// Behavioural two-wire target device hanging on the serial pins
`timescale 1ns/100ps
module gsbh_target_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    // Clock used to sample the wires
    input wire logic core_clk,
    // Wire levels
    input wire logic scl,
    input wire logic sda,
    // Data pull-down and bytes seen since the last start
    output logic sda_low,
    output logic [3:0] byte_count
);
    logic [7:0] mem [256];
    logic [7:0] sh = 8'h00;
    logic [7:0] ptr = 8'h00;
    logic [3:0] cnt = 4'h0;
    logic scl_p = 1'b1;
    logic sda_p = 1'b1;
    logic hit = 1'b0;
    logic rd = 1'b0;
    logic tx = 1'b0;
    initial begin
        sda_low = 1'b0;
        byte_count = 4'h0;
    end
    // Start, stop and clock edges found by sampling the wires
    always @(posedge core_clk) begin
        if (scl && scl_p && sda_p && !sda) begin
            cnt <= 4'h0;
            byte_count <= 4'h0;
            tx <= 1'b0;
            sda_low <= 1'b0;
        end else if (scl && scl_p && !sda_p && sda) begin
            tx <= 1'b0;
            sda_low <= 1'b0;
        end else if (scl && !scl_p) begin
            if (!tx && cnt < 4'h8) sh <= {sh[6:0], sda};
            cnt <= cnt + 4'h1;
        end else if (!scl && scl_p) begin
            if (cnt == 4'h8) begin
                sda_low <= 1'b0; // Released for the host's own acknowledge
                if (!tx) begin
                    // Acknowledge only when addressed
                    if (byte_count == 4'h0) begin
                        hit <= (sh[7:1] == ADDR);
                        rd <= sh[0];
                        sda_low <= (sh[7:1] == ADDR);
                    end else begin
                        sda_low <= hit;
                        if (byte_count == 4'h1) ptr <= sh;
                        else mem[ptr] <= sh;
                    end
                    byte_count <= byte_count + 4'h1;
                end
            end else if (cnt == 4'h9) begin
                // End of acknowledge slot, begin a read byte if asked
                cnt <= 4'h0;
                tx <= !tx && hit && rd;
                sh <= mem[ptr];
                sda_low <= !tx && hit && rd && !mem[ptr][7];
            end else if (tx) begin
                sda_low <= !sh[4'h7 - cnt]; // MSB first
            end
        end
        scl_p <= scl;
        sda_p <= sda;
    end
endmodule : gsbh_target_model

// *** bench/testbench.sv ***
// Self-checking bench for the pin and serial-bus host registers
`timescale 1ns/100ps
module testbench;
    import gsbh_pkg::*;
    localparam logic [6:0] TGT = 7'h2a;
    localparam logic [7:0] OFFS [7] = '{OFF_DIR_LO, OFF_DIR_HI, OFF_LVL_HI, OFF_SBUF,
                                        OFF_SIDX, OFF_STGT, OFF_SCTL};
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] ext = 8'hff;
    logic ser = 1'b0;
    logic [7:0] reg_rdata, gpio_out, gpio_oe, pad, got, dir, stored, dat, idx;
    logic reg_rvalid, sda_low, err_seen;
    logic [3:0] byte_count;
    logic [31:0] seed = 32'd82369;
    int n_errors = 0;
    int tests_run = 0;
    // Wire level of every pin: driven value, else outside level or target pull-down
    assign pad = (gpio_oe & gpio_out) | (~gpio_oe & ext & ~{2'b00, sda_low & ser, 5'h00});
    gsbh_regs #(.QTR_NORMAL(8), .QTR_TEST(2)) i_dut (
        .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .gpio_in(pad), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
    // Target sees idle wires until the pins are handed to the serial bus
    gsbh_target_model #(.ADDR(TGT)) i_target (
        .core_clk(core_clk), .scl(pad[SCL_PIN] | ~ser), .sda(pad[SDA_PIN] | ~ser),
        .sda_low(sda_low), .byte_count(byte_count));
    // Clock
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Level view: stored value on outputs, pin level on inputs
    function automatic logic [7:0] lvl_view(input logic [7:0] d, input logic [7:0] o,
                                            input logic [7:0] p);
        return (d & o) | (~d & p);
    endfunction : lvl_view
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        got = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
        reg_rd = 1'b0;
        err_seen = err_seen | got[CTL_ERROR_BIT];
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(got, e);
    endtask : rchk
    // Launch one transfer, see busy rise, then poll until it falls
    task automatic launch(input logic [7:0] t);
        int n;
        err_seen = 1'b0;
        wr(OFF_STGT, t);
        rd(OFF_SCTL);
        chk(got & 8'h20, 8'h20);
        n = 0;
        while (got[CTL_BUSY_BIT] !== 1'b0 && n < 3000) begin
            rd(OFF_SCTL);
            n++;
        end
        chk({7'h00, got[CTL_BUSY_BIT]}, 8'h00);
    endtask : launch
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    // Watchdog
    initial begin
        #200us;
        n_errors++;
        $display("watchdog expired");
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        foreach (OFFS[i]) rchk(OFFS[i], 8'h00);
        $display("test reset values done");
        stored = 8'h00;
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            dir = (i == 0) ? 8'h00 : seed[7:0];
            dat = (i == 0) ? 8'hff : seed[15:8];
            ext = seed[23:16];
            wr(seed[24] ? CFG_DIR_LO : OFF_DIR_LO, dir);
            wr(seed[25] ? CFG_LVL_LO : OFF_LVL_LO, dat);
            wr(seed[26] ? CFG_DIR_HI : OFF_DIR_HI, 8'hff);
            stored = (stored & ~dir) | (dat & dir);
            repeat (3) @(negedge core_clk);
            chk(gpio_oe, dir);
            chk(gpio_out & dir, stored & dir);
            rchk(seed[27] ? OFF_LVL_LO : CFG_LVL_LO, lvl_view(dir, stored, ext));
            rchk(seed[28] ? CFG_DIR_HI : OFF_DIR_HI, 8'h00);
            rchk(seed[29] ? CFG_LVL_HI : OFF_LVL_HI, 8'h00);
        end
        $display("test pins done");
        ext = 8'hff;
        ser = 1'b1;
        wr(OFF_SCTL, 8'h08);
        wr(OFF_DIR_LO, 8'hff);
        wr(OFF_LVL_LO, 8'hff);
        repeat (3) @(negedge core_clk);
        chk(gpio_oe & SEC_MASK, 8'h00);
        chk(gpio_out, ~SEC_MASK);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            dat = seed[7:0];
            idx = seed[15:8];
            wr(OFF_SBUF, dat);
            wr(OFF_SIDX, idx);
            launch({TGT, 1'b0});
            chk(i_target.mem[idx], dat);
            chk({4'h0, byte_count}, 8'h03);
            chk({7'h00, err_seen}, 8'h00);
            wr(OFF_SBUF, ~dat);
            launch({TGT, 1'b1});
            rchk(OFF_SBUF, dat);
            rchk(OFF_STGT, {TGT, 1'b1});
        end
        $display("test serial transfers done");
        launch({~TGT, 1'b0});
        chk({7'h00, err_seen}, 8'h01);
        rchk(OFF_SCTL, 8'h08);
        wr(OFF_SCTL, 8'h8c);
        wr(OFF_SBUF, idx);
        launch({TGT, 1'b0});
        chk({4'h0, byte_count}, 8'h02);
        launch({TGT, 1'b1});
        chk({4'h0, byte_count}, 8'h01);
        rchk(OFF_SBUF, dat);
        rchk(OFF_SCTL, 8'h8c);
        $display("test error and framing done");
        end_of_test();
    end
endmodule : testbench

// *** hdl/gsbh_pkg.sv ***
// Constants, offsets and types shared by the pin and serial-bus host registers
package gsbh_pkg;
    // Register window geometry
    localparam int BYTE_W = 8;
    localparam int PIN_COUNT = 8;
    // Memory-window byte offsets
    localparam logic [7:0] OFF_DIR_LO = 8'h40;
    localparam logic [7:0] OFF_DIR_HI = 8'h41;
    localparam logic [7:0] OFF_LVL_LO = 8'h42;
    localparam logic [7:0] OFF_LVL_HI = 8'h43;
    localparam logic [7:0] OFF_SBUF = 8'h44;
    localparam logic [7:0] OFF_SIDX = 8'h45;
    localparam logic [7:0] OFF_STGT = 8'h46;
    localparam logic [7:0] OFF_SCTL = 8'h47;
    // Configuration-space aliases of the pin registers
    localparam logic [7:0] CFG_DIR_LO = 8'hb4;
    localparam logic [7:0] CFG_DIR_HI = 8'hb5;
    localparam logic [7:0] CFG_LVL_LO = 8'hb6;
    localparam logic [7:0] CFG_LVL_HI = 8'hb7;
    // Pins taken over by the serial bus
    localparam int SCL_PIN = 4;
    localparam int SDA_PIN = 5;
    localparam logic [7:0] SEC_MASK = 8'h30;
    // Control and status bit positions
    localparam int CTL_FRAMING_BIT = 7;
    localparam int CTL_BUSY_BIT = 5;
    localparam int CTL_ENABLE_BIT = 3;
    localparam int CTL_TEST_BIT = 2;
    localparam int CTL_ERROR_BIT = 1;
    localparam int TGT_RW_BIT = 0;
    // Reset value, top bit number and last quarter phase
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] BIT_TOP = 3'h7;
    localparam logic [1:0] Q_LAST = 2'h3;
    // Serial clock timing, four quarter phases per bit
    localparam int CORE_CLK_KHZ = 250000;
    localparam int SCL_NORMAL_KHZ = 60;
    localparam int SCL_TEST_KHZ = 4000;
    localparam int QTR_NORMAL_CYC = CORE_CLK_KHZ / (SCL_NORMAL_KHZ * 4);
    localparam int QTR_TEST_CYC = CORE_CLK_KHZ / (SCL_TEST_KHZ * 4);
    // Engine states and byte stages
    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_TX, ST_TXACK, ST_RX, ST_RXACK, ST_STOP
    } gsbh_state_t;
    typedef enum logic [2:0] {
        STG_ADDR, STG_INDEX, STG_DATA_W, STG_ADDR_R
    } gsbh_stage_t;
endpackage : gsbh_pkg

// *** hdl/gsbh_qtick.sv ***
// Quarter-bit tick generator for the serial clock
`timescale 1ns/100ps
module gsbh_qtick #(
    parameter int NORMAL_CYC = 1041,
    parameter int TEST_CYC = 15
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Control
    input wire logic run,
    input wire logic fast,
    // One-cycle tick per quarter bit
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } gsbh_qtick_t;
    gsbh_qtick_t s_q, s_d;
    localparam logic [15:0] NORM_LIM = 16'(NORMAL_CYC - 1);
    localparam logic [15:0] TEST_LIM = 16'(TEST_CYC - 1);

    initial begin
        if (NORMAL_CYC < 1 || NORMAL_CYC > 65536 || TEST_CYC < 1 || TEST_CYC > 65536)
            $error("gsbh_qtick counts out of range");
    end

    // Count quarter periods while a transfer runs
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.cnt = '0;
        end else if (s_q.cnt >= (fast ? TEST_LIM : NORM_LIM)) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule : gsbh_qtick

// *** hdl/gsbh_regs.sv ***
// Pin direction/level registers and single-byte two-wire serial host
// Notes on behaviour
// - One direction bit per pin, 0 input
// - Serial function overrides direction on pins 4,5
// - Direction upper byte reads zero, unwritable
// - Level read returns sampled pin for inputs
// - Level write stores and drives output pins
// - Level writes ignored on input or serial pins
// - After reset upper zero, lower shows pins
// - Configuration aliases share the same storage
// - Read byte lands before busy clears
// - Serial registers cleared only by fundamental reset
// - Index holds target byte location, written first
// - Target write launches one transfer when idle and enabled
// - Target address bits 7:1, reset zero
// - Bit 0 selects write (0) or read
// - Framing select: index sent or omitted
// - Busy high from launch until finished
// - Sticky error on failure, cleared by read
// - Enable bit hands pins 4,5 to serial
`timescale 1ns/100ps
module gsbh_regs
    import gsbh_pkg::*;
#(
    parameter int QTR_NORMAL = gsbh_pkg::QTR_NORMAL_CYC,
    parameter int QTR_TEST = gsbh_pkg::QTR_TEST_CYC
) (
    // Clock and fundamental reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register access port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [gsbh_pkg::BYTE_W-1:0] reg_wdata,
    output logic [gsbh_pkg::BYTE_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // General pins, open-drain serial on pins 4 and 5
    input wire logic [gsbh_pkg::PIN_COUNT-1:0] gpio_in,
    output logic [gsbh_pkg::PIN_COUNT-1:0] gpio_out,
    output logic [gsbh_pkg::PIN_COUNT-1:0] gpio_oe
);
    import gsbh_pkg::*;
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] lvl_out;
        logic [7:0] sbuf;
        logic [7:0] sidx;
        logic [7:0] stgt;
        logic framing;
        logic enable;
        logic test;
        logic err;
        logic busy;
        gsbh_state_t st;
        gsbh_stage_t stage;
        logic [1:0] q;
        logic [2:0] bitn;
        logic [7:0] shreg;
        logic scl;
        logic sda;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic [7:0] rdata;
        logic rvalid;
    } gsbh_regs_t;
    gsbh_regs_t s_q, s_d;
    logic [7:0] pin_s;
    logic tick;
    logic [7:0] sec;
    logic [7:0] wmask;
    logic [7:0] lvl_view;
    logic sda_in;
    logic wr_dir, wr_lvl, rd_ctl, launch, end_q, set_err;
    initial if (QTR_NORMAL < 1 || QTR_TEST < 1) $error("gsbh_regs quarter counts invalid");
    // Address hit on the window offset or its configuration alias
    function automatic logic hit(input logic [7:0] a, input logic [7:0] mem_off,
                                 input logic [7:0] cfg_off);
        hit = (a == mem_off) || (a == cfg_off);
    endfunction : hit
    // Pin level synchroniser
    gsbh_sync #(.W(PIN_COUNT)) u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .async_in(gpio_in),
        .sync_out(pin_s)
    );
    // Serial clock quarter ticks, fast rate in test mode
    gsbh_qtick #(.NORMAL_CYC(QTR_NORMAL), .TEST_CYC(QTR_TEST)) u_qtick (
        .core_clk(core_clk),
        .resetn(resetn),
        .run(s_q.busy),
        .fast(s_q.test),
        .tick(tick)
    );
    // Decodes and pin views
    assign sec = s_q.enable ? SEC_MASK : 8'h00;
    assign wmask = s_q.dir & ~sec;
    assign lvl_view = (wmask & s_q.lvl_out) | (~wmask & pin_s);
    assign sda_in = pin_s[SDA_PIN];
    assign wr_dir = reg_wr && hit(reg_addr, OFF_DIR_LO, CFG_DIR_LO);
    assign wr_lvl = reg_wr && hit(reg_addr, OFF_LVL_LO, CFG_LVL_LO);
    assign rd_ctl = reg_rd && (reg_addr == OFF_SCTL);
    assign launch = reg_wr && (reg_addr == OFF_STGT);
    assign end_q = tick && (s_q.q == Q_LAST);
    assign set_err = (launch && s_q.st == ST_IDLE && !s_q.enable)
                     || (s_q.st == ST_TXACK && end_q && sda_in);
    // Next state: registers, engine, pins and read data
    always_comb begin
        s_d = s_q;
        s_d.rvalid = reg_rd;
        // Register writes
        if (wr_dir) begin
            s_d.dir = reg_wdata;
        end
        if (wr_lvl) begin
            s_d.lvl_out = (s_q.lvl_out & ~wmask) | (reg_wdata & wmask);
        end
        if (reg_wr && reg_addr == OFF_SBUF) begin
            s_d.sbuf = reg_wdata;
        end
        if (reg_wr && reg_addr == OFF_SIDX) begin
            s_d.sidx = reg_wdata;
        end
        if (launch) begin
            s_d.stgt = reg_wdata;
        end
        if (reg_wr && reg_addr == OFF_SCTL) begin
            s_d.framing = reg_wdata[CTL_FRAMING_BIT];
            s_d.enable = reg_wdata[CTL_ENABLE_BIT];
            s_d.test = reg_wdata[CTL_TEST_BIT];
        end
        // Error is read-to-clear, a new failure wins
        if (rd_ctl) begin
            s_d.err = 1'b0;
        end
        if (set_err) begin
            s_d.err = 1'b1;
        end
        // Transfer engine, one quarter phase per tick
        case (s_q.st)
            ST_IDLE: begin
                if (launch && s_q.enable) begin
                    s_d.busy = 1'b1;
                    s_d.st = ST_START;
                    s_d.stage = STG_ADDR;
                    s_d.q = 2'h0;
                    s_d.shreg = {reg_wdata[7:1], s_q.framing & reg_wdata[TGT_RW_BIT]};
                end
            end
            ST_START: begin
                if (tick) begin
                    s_d.scl = (s_q.q == 2'h1) || (s_q.q == 2'h2);
                    s_d.sda = (s_q.q == 2'h0) || (s_q.q == 2'h1);
                    s_d.q = s_q.q + 2'h1;
                    if (s_q.q == Q_LAST) begin
                        s_d.st = ST_TX;
                        s_d.bitn = BIT_TOP;
                    end
                end
            end
            ST_TX, ST_TXACK, ST_RX, ST_RXACK: begin
                if (tick) begin
                    s_d.scl = s_q.q[1];
                    s_d.sda = (s_q.st == ST_TX) ? s_q.shreg[7] : 1'b1;
                    s_d.q = s_q.q + 2'h1;
                end
                if (end_q) begin
                    case (s_q.st)
                        ST_TX: begin
                            s_d.shreg = {s_q.shreg[6:0], 1'b0};
                            s_d.bitn = s_q.bitn - 3'h1;
                            if (s_q.bitn == 3'h0) s_d.st = ST_TXACK;
                        end
                        ST_TXACK: begin
                            s_d.bitn = BIT_TOP;
                            if (sda_in) begin
                                s_d.st = ST_STOP;
                            end else begin
                                case (s_q.stage)
                                    STG_ADDR: begin
                                        if (!s_q.framing) begin
                                            s_d.stage = STG_INDEX;
                                            s_d.shreg = s_q.sidx;
                                            s_d.st = ST_TX;
                                        end else if (s_q.stgt[TGT_RW_BIT]) begin
                                            s_d.st = ST_RX;
                                        end else begin
                                            s_d.stage = STG_DATA_W;
                                            s_d.shreg = s_q.sbuf;
                                            s_d.st = ST_TX;
                                        end
                                    end
                                    STG_INDEX: begin
                                        if (s_q.stgt[TGT_RW_BIT]) begin
                                            s_d.stage = STG_ADDR_R;
                                            s_d.shreg = {s_q.stgt[7:1], 1'b1};
                                            s_d.st = ST_START;
                                        end else begin
                                            s_d.stage = STG_DATA_W;
                                            s_d.shreg = s_q.sbuf;
                                            s_d.st = ST_TX;
                                        end
                                    end
                                    STG_ADDR_R: s_d.st = ST_RX;
                                    default: s_d.st = ST_STOP;
                                endcase
                            end
                        end
                        ST_RX: begin
                            s_d.shreg = {s_q.shreg[6:0], sda_in};
                            s_d.bitn = s_q.bitn - 3'h1;
                            if (s_q.bitn == 3'h0) s_d.st = ST_RXACK;
                        end
                        default: begin
                            s_d.sbuf = s_q.shreg;
                            s_d.st = ST_STOP;
                        end
                    endcase
                end
            end
            ST_STOP: begin
                if (tick) begin
                    s_d.scl = (s_q.q != 2'h0);
                    s_d.sda = s_q.q[1];
                    s_d.q = s_q.q + 2'h1;
                    if (s_q.q == Q_LAST) begin
                        s_d.st = ST_IDLE;
                        s_d.busy = 1'b0;
                    end
                end
            end
            default: begin
                s_d.st = ST_IDLE;
                s_d.busy = 1'b0;
            end
        endcase
        // Pin drivers; serial pins only ever pull low
        s_d.pin_out = s_q.lvl_out & ~sec;
        s_d.pin_oe = s_q.dir & ~sec;
        if (s_q.enable) begin
            s_d.pin_oe[SCL_PIN] = ~s_q.scl;
            s_d.pin_oe[SDA_PIN] = ~s_q.sda;
        end
        // Read data, unmapped and reserved bytes read zero
        s_d.rdata = RST_BYTE;
        if (reg_rd) begin
            if (hit(reg_addr, OFF_DIR_LO, CFG_DIR_LO)) s_d.rdata = s_q.dir;
            else if (hit(reg_addr, OFF_LVL_LO, CFG_LVL_LO)) s_d.rdata = lvl_view;
            else if (reg_addr == OFF_SBUF) s_d.rdata = s_q.sbuf;
            else if (reg_addr == OFF_SIDX) s_d.rdata = s_q.sidx;
            else if (reg_addr == OFF_STGT) s_d.rdata = s_q.stgt;
            else if (reg_addr == OFF_SCTL) begin
                s_d.rdata[CTL_FRAMING_BIT] = s_q.framing;
                s_d.rdata[CTL_BUSY_BIT] = s_q.busy;
                s_d.rdata[CTL_ENABLE_BIT] = s_q.enable;
                s_d.rdata[CTL_TEST_BIT] = s_q.test;
                s_d.rdata[CTL_ERROR_BIT] = s_q.err;
            end
        end
    end
    // State register, cleared only by the fundamental reset
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.scl <= 1'b1;
            s_q.sda <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end
    // Outputs from flip-flops
    assign reg_rdata = s_q.rdata;
    assign reg_rvalid = s_q.rvalid;
    assign gpio_out = s_q.pin_out;
    assign gpio_oe = s_q.pin_oe;
    // Upper direction byte reads zero
    property p_dir_hi_zero;
        @(posedge core_clk) disable iff (!resetn)
        reg_rd && hit(reg_addr, OFF_DIR_HI, CFG_DIR_HI) |=> reg_rvalid && reg_rdata == 8'h00;
    endproperty
    a_dir_hi_zero: assert property (p_dir_hi_zero) else $error("dir upper byte not zero");
    // Written level bits land only where the pin is an output
    property p_lvl_store;
        @(posedge core_clk) disable iff (!resetn)
        wr_lvl |=> (s_q.lvl_out & $past(wmask)) == ($past(reg_wdata) & $past(wmask));
    endproperty
    a_lvl_store: assert property (p_lvl_store) else $error("output level not stored");
    property p_lvl_ignore;
        @(posedge core_clk) disable iff (!resetn)
        wr_lvl |=> ((s_q.lvl_out ^ $past(s_q.lvl_out)) & ~$past(wmask)) == 8'h00;
    endproperty
    a_lvl_ignore: assert property (p_lvl_ignore) else $error("ignored level bit changed");
    // Plain pins follow their direction bits one cycle later
    property p_dir_oe;
        @(posedge core_clk) disable iff (!resetn)
        !s_q.enable |=> gpio_oe == $past(s_q.dir);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("pin enable not from direction");
    // Idle serial pins are released regardless of direction
    property p_sec_release;
        @(posedge core_clk) disable iff (!resetn)
        s_q.enable && s_q.st == ST_IDLE && s_q.scl && s_q.sda
        |=> gpio_oe[SDA_PIN] == 1'b0 && gpio_oe[SCL_PIN] == 1'b0;
    endproperty
    a_sec_release: assert property (p_sec_release) else $error("serial pin driven at idle");
    property p_launch_busy;
        @(posedge core_clk) disable iff (!resetn)
        launch && s_q.st == ST_IDLE && s_q.enable |=> s_q.busy && s_q.st == ST_START;
    endproperty
    a_launch_busy: assert property (p_launch_busy) else $error("launch did not set busy");
    // Busy falls only at the end of a stop
    property p_busy_end;
        @(posedge core_clk) disable iff (!resetn)
        $fell(s_q.busy) |-> $past(s_q.st) == ST_STOP && s_q.sda && s_q.scl;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy dropped outside stop");
    // Missing acknowledge sets the error
    property p_nack_err;
        @(posedge core_clk) disable iff (!resetn)
        s_q.st == ST_TXACK && end_q && sda_in |=> s_q.err && s_q.st == ST_STOP;
    endproperty
    a_nack_err: assert property (p_nack_err) else $error("nack not flagged");
    // Error read clears unless a new failure arrives
    property p_err_clear;
        @(posedge core_clk) disable iff (!resetn)
        rd_ctl && !set_err |=> !s_q.err;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error not cleared by read");
    // Received byte lands in the buffer before busy clears
    property p_rx_load;
        @(posedge core_clk) disable iff (!resetn)
        s_q.st == ST_RXACK && end_q |=> s_q.sbuf == $past(s_q.shreg) && s_q.busy;
    endproperty
    a_rx_load: assert property (p_rx_load) else $error("read byte not loaded");
endmodule : gsbh_regs

// *** hdl/gsbh_sync.sv ***
// Two-flop synchroniser for pin levels
`timescale 1ns/100ps
module gsbh_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] held;
    } gsbh_sync_t;
    gsbh_sync_t s_q, s_d;

    initial begin
        if (W < 1) $error("gsbh_sync width must be at least one");
    end

    // First stage feeds only the second
    always_comb begin
        s_d.meta = async_in;
        s_d.held = s_q.meta;
    end

    // State register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.held;
endmodule : gsbh_sync
